// *** pin_select_map.svh ***
// Purpose: constants for the pin function select block
// Assumes: included by its bare name
// Notes: bit positions and reset values only
`ifndef PIN_SELECT_MAP_SVH
`define PIN_SELECT_MAP_SVH
`define PK_ECS_BIT 7
`define PK_XCS_BIT 6
`define PG_RXER_BIT 6
`define PG_RXDV_BIT 5
`define PG_RXCLK_BIT 4
`define PH_TXER_BIT 6
`define PH_TXEN_BIT 5
`define PH_TXCLK_BIT 4
`define PULLUP_RESET 1'h1
`define XMASK_RESET 1'h1
`define PORT_RESET 8'h00
`define WAKE_RESET 8'h00
`endif

// *** pin_select_pkg.sv ***
// Purpose: types for the pin function select block
// Assumes: nothing
// Notes: port groups carried as packed structs
package pin_select_pkg;
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] dir;
   } gpio_ctl_t;
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } pin_drive_t;
   typedef struct packed {
      logic rx_er;
      logic rx_dv;
      logic rx_clk;
      logic [3:0] rxd;
   } mii_rx_t;
   typedef struct packed {
      logic tx_er;
      logic tx_en;
      logic [3:0] txd;
   } mii_tx_t;
   typedef struct packed {
      logic ecs_n;
      logic xcs_n;
      logic [5:0] xaddr;
   } ext_bus_t;
   typedef enum logic [1:0] {
      ST_RESET = 2'h0,
      ST_STRAP = 2'h1,
      ST_RUN = 2'h3
   } run_state_t;
endpackage

// *** key_wake.sv ***
// Purpose: key wakeup flags for one 8-bit port
// Assumes: pins synchronous to sys_clk
// Notes: set wins over clear
module key_wake
   import pin_select_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // control
   input wire logic [7:0] enable,
   input wire logic [7:0] clear,
   input wire logic [7:0] pins,
   // status
   output logic [7:0] flags
);
   logic [7:0] prev;
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         prev <= 8'hFF;
      else
         prev <= pins;
   end
   // falling edge on an enabled pin sets the flag
   genvar i;
   generate
      for (i = 0; i < 8; i++)
      begin : g_bit
         always_ff @(posedge sys_clk)
         begin
            if (reset)
               flags[i] <= 1'h0;
            else if (enable[i] && prev[i] && !pins[i])
               flags[i] <= 1'h1;
            else if (clear[i])
               flags[i] <= 1'h0;
         end
      end
   endgenerate
endmodule

// *** port_mux.sv ***
// Purpose: one 8-bit port, gpio or alternate function
// Assumes: alt_sel per bit, alt_oe per bit
// Notes: registered drive
module port_mux
   import pin_select_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // gpio side
   input pin_select_pkg::gpio_ctl_t gpio,
   // alternate side
   input wire logic [7:0] alt_sel,
   input wire logic [7:0] alt_out,
   input wire logic [7:0] alt_oe,
   // pins
   output pin_select_pkg::pin_drive_t drive
);
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         drive <= '0;
      else
      begin
         drive.out <= (alt_sel & alt_out) | (~alt_sel & gpio.data);
         drive.oe <= (alt_sel & alt_oe) | (~alt_sel & gpio.dir);
      end
   end
endmodule

// *** pin_select_top.sv ***
// Purpose: pin function selection for E0, K, AD, G and H pins
// Assumes: all inputs synchronous to sys_clk
// Notes: pins undriven while reset is high

`include "pin_select_map.svh"

// Summary of operation
// R1: nmi pin is input only, readable any time
// R2: nmi mask set by reset, requests ignored until software clears it
// R3: nmi is level sensitive, shareable by wired-or low sources
// R4: port e pull-up on from reset until software clears its enable
// R5: expanded with emulation enable, k7 drives emulation chip select
// R6: expanded modes latch k7 level into rom enable at reset release
// R7: expanded with emulation enable, k6 drives external chip select
// R8: expanded with emulation enable, k5..k0 drive address bits 19..14
// R9: port k pull-ups on from reset until software clears enable
// R10: analog pins readable as digital inputs when enabled
// R11: ports g and h high impedance during and right after reset
// R12: each g and h pin can raise key wakeup
// R13: mii enabled, g6 takes receive error
// R14: mii enabled, g5 receive valid, g3..g0 receive data
// R15: mii enabled, g4 takes receive clock
// R16: mii enabled, h6 drives transmit error
// R17: mii enabled, h5 transmit enable, h3 data bit 3
// R18: mii enabled, h4 takes transmit clock
// R19: mii enabled, h2..h0 drive data bits 2..0
// R20: function disabled returns pins to gpio data and direction
module pin_select_top
   import pin_select_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // non-maskable interrupt pin
   input wire logic nonmaskable_irq_n,
   input wire logic nmi_mask_clear,
   output logic port_e_bit0,
   output logic nmi_request,
   output logic nmi_mask,
   // pull-up control
   input wire logic port_e_pullup_clear,
   input wire logic port_k_pullup_clear,
   output logic port_e_pullup_en,
   output logic port_k_pullup_en,
   // mode and external bus
   input wire logic expanded_mode,
   input wire logic port_k_emul_en,
   input wire pin_select_pkg::ext_bus_t ext_bus,
   input wire logic [7:0] port_k_in,
   input wire pin_select_pkg::gpio_ctl_t port_k_ctl,
   output pin_select_pkg::pin_drive_t port_k_drive,
   output logic rom_enable_bit,
   // analog port
   input wire logic [7:0] analog_inputs,
   input wire logic [7:0] analog_digital_en,
   output logic [7:0] analog_digital_in,
   // ports g and h
   input wire logic mii_ext_en,
   input wire logic [7:0] port_g_in,
   input wire logic [7:0] port_h_in,
   input wire pin_select_pkg::gpio_ctl_t port_g_ctl,
   input wire pin_select_pkg::gpio_ctl_t port_h_ctl,
   input wire pin_select_pkg::mii_tx_t mii_tx,
   output pin_select_pkg::pin_drive_t port_g_drive,
   output pin_select_pkg::pin_drive_t port_h_drive,
   output pin_select_pkg::mii_rx_t mii_rx,
   output logic mii_tx_clk,
   // key wakeup
   input wire logic [7:0] port_g_wake_en,
   input wire logic [7:0] port_h_wake_en,
   input wire logic [7:0] port_g_wake_clear,
   input wire logic [7:0] port_h_wake_clear,
   output logic [7:0] port_g_wake,
   output logic [7:0] port_h_wake,
   output logic wake_request
);
   import pin_select_pkg::*;

   run_state_t state;
   run_state_t next_state;
   logic ext_active;
   logic [7:0] k_alt_out;
   logic [7:0] k_alt_oe;
   logic [7:0] k_alt_sel;
   logic [7:0] h_alt_out;
   logic [7:0] g_flags;
   logic [7:0] h_flags;

   // bits 6..0 belong to the mac while the external mii is on; bit 7 stays gpio
   function automatic logic [7:0] mii_alt_sel(input logic en);
      return en ? 8'h7F : 8'h00;
   endfunction

   // reset sequencing: strap taken one clock after release
   always_comb
   begin
      case (state)
         ST_RESET: next_state = ST_STRAP;
         ST_STRAP: next_state = ST_RUN;
         ST_RUN: next_state = ST_RUN;
         default: next_state = ST_RESET;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
         state <= ST_RESET;
      else
         state <= next_state;
   end

   // nmi pin is never driven, only sampled; level kept, no edge capture
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         port_e_bit0 <= 1'h1;
      else
         port_e_bit0 <= nonmaskable_irq_n; // [R1]
   end

   // mask cannot be set again by software once cleared
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         nmi_mask <= `XMASK_RESET; // [R2]
      else if (nmi_mask_clear)
         nmi_mask <= 1'h0; // [R2]
   end

   // request follows the level so any low source holds it
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         nmi_request <= 1'h0;
      else
         nmi_request <= !nonmaskable_irq_n && !nmi_mask && !nmi_mask_clear; // [R2] [R3]
   end

   // pull-ups
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         port_e_pullup_en <= `PULLUP_RESET; // [R4]
      else if (port_e_pullup_clear)
         port_e_pullup_en <= 1'h0; // [R4]
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
         port_k_pullup_en <= `PULLUP_RESET; // [R9]
      else if (port_k_pullup_clear)
         port_k_pullup_en <= 1'h0; // [R9]
   end

   // rom enable strap, caught after release since async capture of a pin is unsafe
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         rom_enable_bit <= 1'h0;
      else if (state == ST_STRAP && expanded_mode)
         rom_enable_bit <= port_k_in[`PK_ECS_BIT]; // [R6]
   end

   // port k alternate functions
   assign ext_active = expanded_mode && port_k_emul_en && state == ST_RUN;
   always_comb
   begin
      k_alt_out = {ext_bus.ecs_n, ext_bus.xcs_n, ext_bus.xaddr}; // [R5] [R7] [R8]
      k_alt_oe = 8'hFF;
      k_alt_sel = ext_active ? 8'hFF : 8'h00; // [R20]
   end

   port_mux u_port_k (
      .sys_clk(sys_clk),
      .reset(reset),
      .gpio(port_k_ctl),
      .alt_sel(k_alt_sel),
      .alt_out(k_alt_out),
      .alt_oe(k_alt_oe),
      .drive(port_k_drive)
   );

   // analog port as digital input
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         analog_digital_in <= `PORT_RESET;
      else
         analog_digital_in <= analog_inputs & analog_digital_en; // [R10]
   end

   // port g: all mii functions are inputs, so the pin is never driven then
   port_mux u_port_g (
      .sys_clk(sys_clk),
      .reset(reset),
      .gpio(port_g_ctl),
      .alt_sel(mii_alt_sel(mii_ext_en)), // [R20]
      .alt_out(8'h00),
      .alt_oe(8'h00), // [R13] [R14] [R15]
      .drive(port_g_drive) // [R11]
   );

   // receive side held at zero while mii is off so the mac never sees gpio traffic
   always_ff @(posedge sys_clk)
   begin
      if (reset || !mii_ext_en)
         mii_rx.rx_er <= 1'h0;
      else
         mii_rx.rx_er <= port_g_in[`PG_RXER_BIT]; // [R13]
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset || !mii_ext_en)
         mii_rx.rx_dv <= 1'h0;
      else
         mii_rx.rx_dv <= port_g_in[`PG_RXDV_BIT]; // [R14]
   end

   // receive clock is only sampled, so it must be well below sys_clk
   always_ff @(posedge sys_clk)
   begin
      if (reset || !mii_ext_en)
         mii_rx.rx_clk <= 1'h0;
      else
         mii_rx.rx_clk <= port_g_in[`PG_RXCLK_BIT]; // [R15]
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset || !mii_ext_en)
         mii_rx.rxd <= 4'h0;
      else
         mii_rx.rxd <= port_g_in[3:0]; // [R14]
   end

   // port h: bit 4 is the phy's transmit clock, an input
   always_comb
   begin
      h_alt_out = {1'h0, mii_tx.tx_er, mii_tx.tx_en, 1'h0, mii_tx.txd}; // [R16] [R17] [R19]
   end

   port_mux u_port_h (
      .sys_clk(sys_clk),
      .reset(reset),
      .gpio(port_h_ctl),
      .alt_sel(mii_alt_sel(mii_ext_en)), // [R20]
      .alt_out(h_alt_out),
      .alt_oe(8'h6F), // [R18]
      .drive(port_h_drive) // [R11]
   );

   always_ff @(posedge sys_clk)
   begin
      if (reset || !mii_ext_en)
         mii_tx_clk <= 1'h0;
      else
         mii_tx_clk <= port_h_in[`PH_TXCLK_BIT]; // [R18]
   end

   // key wakeup flags
   key_wake u_wake_g (
      .sys_clk(sys_clk),
      .reset(reset),
      .enable(port_g_wake_en),
      .clear(port_g_wake_clear),
      .pins(port_g_in),
      .flags(g_flags) // [R12]
   );

   key_wake u_wake_h (
      .sys_clk(sys_clk),
      .reset(reset),
      .enable(port_h_wake_en),
      .clear(port_h_wake_clear),
      .pins(port_h_in),
      .flags(h_flags) // [R12]
   );

   // outputs come from flops here, costing one cycle of wakeup latency
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         port_g_wake <= `WAKE_RESET;
      else
         port_g_wake <= g_flags; // [R12]
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
         port_h_wake <= `WAKE_RESET;
      else
         port_h_wake <= h_flags; // [R12]
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
         wake_request <= 1'h0;
      else
         wake_request <= |{g_flags, h_flags}; // [R12]
   end
endmodule

// *** mii_phy_model.sv ***
// Purpose: behavioural phy on the mii pins of ports g and h
// Assumes: frame high while the phy is sending
// Notes: clocks stand still outside frames
module mii_phy_model
(
   // clock and control
   input wire logic sys_clk,
   input wire logic frame,
   // pins toward the device
   output logic [6:0] rx_pins,
   output logic tx_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0] rx = 7'h00;
   logic txc = 1'h0;
   assign rx_pins = rx;
   assign tx_clk = txc;
   always @(posedge sys_clk)
   begin
      if (frame)
      begin
         rx[4] <= ~rx[4];
         txc <= ~txc;
         rx[6:5] <= 2'h1;
         rx[3:0] <= rx[3:0] + 4'h1;
      end
      else
      begin
         rx[6:5] <= 2'h0;
         rx[3:0] <= ~rx[3:0]; // no pull on data, so never a stale value
      end
   end
endmodule

// *** pin_select_assertions.sv ***
// Purpose: port checks for the pin function select block
// Assumes: bound to pin_select_top
// Notes: k alternate drive checked from the fourth clean edge
module pin_select_checker
   import pin_select_pkg::*;
(
   // watched ports
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic nonmaskable_irq_n,
   input wire logic port_e_pullup_clear,
   input wire logic expanded_mode,
   input wire logic port_k_emul_en,
   input wire pin_select_pkg::ext_bus_t ext_bus,
   input wire logic [7:0] analog_inputs,
   input wire logic [7:0] analog_digital_en,
   input wire logic mii_ext_en,
   input wire logic [7:0] port_g_in,
   input wire logic [7:0] port_h_in,
   input wire pin_select_pkg::mii_tx_t mii_tx,
   input wire logic nmi_request,
   input wire logic nmi_mask,
   input wire logic port_e_pullup_en,
   input wire logic port_k_pullup_en,
   input wire pin_select_pkg::pin_drive_t port_k_drive,
   input wire pin_select_pkg::pin_drive_t port_g_drive,
   input wire pin_select_pkg::pin_drive_t port_h_drive,
   input wire logic [7:0] analog_digital_in,
   input wire pin_select_pkg::mii_rx_t mii_rx,
   input wire logic mii_tx_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   property p_reset_state;
      $past(reset) |-> nmi_mask && port_e_pullup_en && port_k_pullup_en;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("reset state");
   property p_hiz;
      $past(reset) |-> (port_g_drive.oe | port_h_drive.oe | port_k_drive.oe) == 8'h00;
   endproperty
   a_hiz: assert property (p_hiz) else $error("pins driven in reset");
   property p_nmi;
      !$past(reset) |-> nmi_request == (!$past(nonmaskable_irq_n) && !$past(nmi_mask));
   endproperty
   a_nmi: assert property (p_nmi) else $error("nmi request");
   property p_pull_off;
      !$past(reset) && $past(port_e_pullup_clear) |-> !port_e_pullup_en ##1 !port_e_pullup_en;
   endproperty
   a_pull_off: assert property (p_pull_off) else $error("pull-up clear");
   property p_k_alt;
      !$past(reset) && !$past(reset, 2) && !$past(reset, 3) && $past(expanded_mode && port_k_emul_en)
         |-> port_k_drive == {$past(ext_bus), 8'hFF};
   endproperty
   a_k_alt: assert property (p_k_alt) else $error("port k alternate");
   property p_h_tx;
      !$past(reset) && $past(mii_ext_en) |-> port_h_drive.oe[6:0] == 7'h6F && port_g_drive.oe[6:0] == 7'h00
         && {port_h_drive.out[6:5], port_h_drive.out[3:0]} == $past(mii_tx);
   endproperty
   a_h_tx: assert property (p_h_tx) else $error("mii transmit pins");
   property p_rx;
      !$past(reset) |-> mii_rx == ($past(mii_ext_en) ? $past(port_g_in[6:0]) : 7'h00)
         && mii_tx_clk == ($past(mii_ext_en) && $past(port_h_in[4]));
   endproperty
   a_rx: assert property (p_rx) else $error("mii receive pins");
   property p_analog;
      !$past(reset) |-> analog_digital_in == $past(analog_inputs & analog_digital_en);
   endproperty
   a_analog: assert property (p_analog) else $error("analog digital in");
   c_nmi: cover property (nmi_request);
   c_alt: cover property (expanded_mode && port_k_emul_en && mii_ext_en);
   c_pull: cover property (!port_k_pullup_en);
endmodule
bind pin_select_top pin_select_checker u_pin_select_checker (.*);

// *** testbench.sv ***
// Purpose: self-checking bench for the pin function select block
// Assumes: inputs change on the falling edge
// Notes: phy model feeds the mii pins only while mii is on
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import pin_select_pkg::*;
   typedef struct packed {
      logic [2:0] m;
      logic [15:0] c;
      logic [7:0] b;
      logic [5:0] t;
      logic [15:0] k, g, h;
   } row_t;
   // m is {expanded, emulation, mii}; k g h are {out & oe, oe}
   localparam row_t ROWS [5] = '{
      {3'h2, 16'hA53C, 8'h96, 6'h2A, 16'h243C, 16'h243C, 16'h243C},
      {3'h4, 16'h5AC3, 8'h96, 6'h2A, 16'h42C3, 16'h42C3, 16'h42C3},
      {3'h6, 16'hA53C, 8'h96, 6'h2A, 16'h96FF, 16'h243C, 16'h243C},
      {3'h1, 16'hA53C, 8'h96, 6'h29, 16'h243C, 16'h0000, 16'h496F},
      {3'h7, 16'h5AC3, 8'h4B, 6'h16, 16'h4BFF, 16'h0080, 16'h26EF}};
   logic sys_clk = 1'h0, reset = 1'h1, nmi_a = 1'h1, nmi_b = 1'h1, frame = 1'h0;
   logic nmi_mask_clear, port_e_pullup_clear, port_k_pullup_clear, expanded_mode, port_k_emul_en, mii_ext_en;
   logic nonmaskable_irq_n, port_e_bit0, nmi_request, nmi_mask, port_e_pullup_en, port_k_pullup_en;
   logic rom_enable_bit, mii_tx_clk, wake_request, phy_txclk;
   logic [7:0] port_k_in, analog_inputs, analog_digital_en, analog_digital_in, port_g_in, port_h_in, g_pins, h_pins;
   logic [7:0] port_g_wake_en, port_h_wake_en, port_g_wake_clear, port_h_wake_clear, port_g_wake, port_h_wake;
   logic [6:0] phy_rx;
   ext_bus_t ext_bus;
   gpio_ctl_t port_k_ctl, port_g_ctl, port_h_ctl;
   mii_tx_t mii_tx;
   mii_rx_t mii_rx;
   pin_drive_t port_k_drive, port_g_drive, port_h_drive;
   int err_total = 0, total_checks = 0, cycles = 0;
   assign nonmaskable_irq_n = nmi_a & nmi_b; // two low-active sources share the line
   assign port_g_in = mii_ext_en ? {g_pins[7], phy_rx} : g_pins;
   assign port_h_in = mii_ext_en ? {h_pins[7:5], phy_txclk, h_pins[3:0]} : h_pins;
   always #25 sys_clk = ~sys_clk;
   pin_select_top u_pin_select_top (.*);
   mii_phy_model u_mii_phy_model (.sys_clk(sys_clk), .frame(frame), .rx_pins(phy_rx), .tx_clk(phy_txclk));
   function automatic logic [15:0] shown(input pin_drive_t d);
      return {d.out & d.oe, d.oe};
   endfunction
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 600)
      begin
         err_total++;
         wrap_up();
      end
   end
   initial
   begin
      {nmi_mask_clear, port_e_pullup_clear, port_k_pullup_clear, port_k_emul_en, mii_ext_en} = 5'h00;
      expanded_mode = 1'h1;
      port_k_in = 8'hFF; // strap pin left to its pull-up
      {analog_inputs, analog_digital_en, g_pins, h_pins} = 32'h0000FFFF;
      {port_g_wake_en, port_h_wake_en, port_g_wake_clear, port_h_wake_clear} = 32'h00000000;
      {ext_bus, port_k_ctl, port_g_ctl, port_h_ctl, mii_tx} = '0;
      tick(6);
      reset = 1'h0;
      tick(3);
      chk({rom_enable_bit, nmi_mask, port_e_pullup_en, port_k_pullup_en}, 4'hF);
      $display("reset done");
      foreach (ROWS[i])
      begin
         {expanded_mode, port_k_emul_en, mii_ext_en} = ROWS[i].m;
         frame = ROWS[i].m[0];
         port_k_ctl = ROWS[i].c;
         port_g_ctl = ROWS[i].c;
         port_h_ctl = ROWS[i].c;
         ext_bus = ROWS[i].b;
         mii_tx = ROWS[i].t;
         tick(3);
         chk(shown(port_k_drive), ROWS[i].k);
         chk(shown(port_g_drive), ROWS[i].g);
         chk(shown(port_h_drive), ROWS[i].h);
      end
      $display("mux table done");
      nmi_a = 1'h0;
      tick(3);
      chk({port_e_bit0, nmi_request}, 2'h0);
      nmi_mask_clear = 1'h1;
      tick(1);
      nmi_mask_clear = 1'h0;
      tick(2);
      chk({nmi_mask, nmi_request}, 2'h1);
      nmi_a = 1'h1;
      nmi_b = 1'h0;
      tick(2);
      chk(nmi_request, 1'h1);
      nmi_b = 1'h1;
      tick(2);
      chk({port_e_bit0, nmi_request}, 2'h2);
      $display("nmi done");
      port_e_pullup_clear = 1'h1;
      tick(1);
      port_e_pullup_clear = 1'h0;
      tick(2);
      chk({port_e_pullup_en, port_k_pullup_en}, 2'h1);
      port_k_pullup_clear = 1'h1;
      tick(1);
      port_k_pullup_clear = 1'h0;
      tick(2);
      chk({port_e_pullup_en, port_k_pullup_en}, 2'h0);
      analog_inputs = 8'hF0;
      analog_digital_en = 8'h3C;
      tick(2);
      chk(analog_digital_in, 8'h30);
      $display("pull-up and analog done");
      mii_ext_en = 1'h0;
      frame = 1'h0;
      port_g_wake_en = 8'h08;
      port_h_wake_en = 8'h80;
      tick(2);
      g_pins = 8'hF6; // bit 0 falls too but is not enabled
      h_pins = 8'h7F;
      tick(4);
      chk({wake_request, port_g_wake, port_h_wake}, 17'h10880);
      port_g_wake_clear = 8'hFF;
      port_h_wake_clear = 8'hFF;
      tick(1);
      port_g_wake_clear = 8'h00;
      port_h_wake_clear = 8'h00;
      tick(3);
      chk({wake_request, port_g_wake, port_h_wake}, 17'h00000);
      $display("wake done");
      reset = 1'h1;
      port_k_in = 8'h7F; // strap pin pulled low from outside
      tick(6);
      reset = 1'h0;
      tick(3);
      chk({rom_enable_bit, nmi_mask, port_e_pullup_en, port_k_pullup_en}, 4'h7);
      $display("second reset done");
      wrap_up();
   end
endmodule
